// file: testbench/tb.sv
/*
  Self-checking bench for the setup configuration bank: APB register
  traffic, active setup decode and offset calibration against a model.
  Assumes the bank's package; the master waits for pready however long.
*/
`timescale 1ns/10ps

module tb
  import acb_pkg::*;
;
  logic           core_clk;
  logic           sys_rst;
  logic           clk_en;
  acb_apb_req_t   apb_req;
  acb_apb_rsp_t   apb_rsp;
  logic [2:0]     active_setup;
  logic           cal_valid;
  logic [15:0]    cal_offset;
  acb_setup_act_t active_settings;
  logic [15:0]    active_offset;
  int             bad_count;
  int             check_count;
  int             cyc;
  logic [31:0]    lfsr;
  logic [31:0]    rd;
  logic           er;
  logic [15:0]    cfg_m [8];
  logic [15:0]    offs_m [8];
  int             exc_tab [8] = '{0, 10000, 20000, 50000, 100000, 150000, 200000, 100};
  int             burn_tab [4] = '{0, 500, 2000, 4000};

  acb_setup_bank dut (
    .core_clk       (core_clk),
    .sys_rst        (sys_rst),
    .clk_en         (clk_en),
    .apb_req        (apb_req),
    .apb_rsp        (apb_rsp),
    .active_setup   (active_setup),
    .cal_valid      (cal_valid),
    .cal_offset     (cal_offset),
    .active_settings(active_settings),
    .active_offset  (active_offset)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Run far past the expected few hundred cycles before giving up
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  function automatic logic [31:0] lfsr_next(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic acb_setup_act_t exp_act(logic [15:0] w);
    acb_setup_act_t e;
    e.excite_source_b_level = w[15:13];
    e.excite_b_na = 18'(exc_tab[w[15:13]]);
    e.excite_source_a_level = w[12:10];
    e.excite_a_na = 18'(exc_tab[w[12:10]]);
    e.burnout_level = w[9:8];
    e.burnout_na = 12'(burn_tab[w[9:8]]);
    e.ref_pos_buffer_on = w[7];
    e.ref_neg_buffer_on = w[6];
    e.ref_sel = acb_ref_sel_t'(w[5:4]);
    e.amp_bypass = w[0];
    // Bypass hides the gain code entirely
    e.amp_gain_code = w[0] ? 3'h0 : w[3:1];
    e.amp_gain = w[0] ? 8'h01 : 8'(1 << w[3:1]);
    return e;
  endfunction

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge core_clk);
    apb_req.paddr <= a;
    apb_req.pwrite <= w;
    apb_req.pwdata <= d;
    apb_req.pstrb <= s;
    apb_req.psel <= 1'b1;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic show(input int s);
    @(posedge core_clk);
    active_setup <= 3'(s);
    settle();
    check(80'(active_settings), 80'(exp_act(cfg_m[s])));
    check(80'(active_offset), 80'(offs_m[s]));
  endtask

  task automatic wr_cfg(input int s, input logic [15:0] w, input logic [3:0] st);
    apb(12'h064 + 12'(4 * s), 1'b1, {16'h0000, w}, st, rd, er);
    if (st[0]) cfg_m[s][7:0] = w[7:0];
    if (st[1]) cfg_m[s][15:8] = w[15:8];
    apb(12'h064 + 12'(4 * s), 1'b0, 32'h00000000, 4'h0, rd, er);
    check(80'(rd), 80'(cfg_m[s]));
    check(80'(er), 80'(1'b0));
  endtask

  // Model back to reset, then every word read
  task automatic reset_check();
    for (int s = 0; s < 8; s++) begin
      cfg_m[s] = 16'h0000;
      offs_m[s] = 16'h8000;
      apb(12'h064 + 12'(4 * s), 1'b0, 32'h0, 4'h0, rd, er);
      check(80'(rd), 80'h0);
      apb(12'h0a4 + 12'(4 * s), 1'b0, 32'h0, 4'h0, rd, er);
      check(80'(rd), 80'h8000);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    apb_req = '0;
    active_setup = 3'h0;
    cal_valid = 1'b0;
    cal_offset = 16'h0000;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    lfsr = 32'hc933;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    // Reset values of all words
    reset_check();
    show(0);
    // Every code of every field, gain unbypassed
    for (int k = 0; k < 8; k++) begin
      wr_cfg(k, {3'(k), ~3'(k), 2'(k), k[0], ~k[0], 2'(k >> 1), 3'(k), 1'b0}, 4'hf);
      show(k);
    end
    // Random words, bypass forced on odd setups
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      wr_cfg(k, lfsr[15:0] | {15'h0, k[0]}, 4'hf);
      show(k);
    end
    // Byte lanes written alone
    lfsr = lfsr_next(lfsr);
    wr_cfg(2, lfsr[15:0], 4'h1);
    wr_cfg(5, ~lfsr[15:0], 4'h2);
    show(2);
    show(5);
    // Unmapped and misaligned places are refused
    apb(12'h084, 1'b0, 32'h0, 4'h0, rd, er);
    check(80'({er, rd}), 80'({1'b1, 32'h0}));
    apb(12'h060, 1'b1, 32'h0000ffff, 4'hf, rd, er);
    check(80'(er), 80'(1'b1));
    apb(12'h065, 1'b1, 32'h0000ffff, 4'hf, rd, er);
    check(80'(er), 80'(1'b1));
    wr_cfg(0, ~cfg_m[0], 4'h0);
    // Calibration lands in the active setup's offset
    for (int s = 0; s < 8; s++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge core_clk);
      active_setup <= 3'(7 - s);
      cal_valid <= 1'b1;
      cal_offset <= lfsr[15:0];
      offs_m[7 - s] = lfsr[15:0];
      @(posedge core_clk);
      cal_valid <= 1'b0;
      settle();
      check(80'(active_offset), 80'(offs_m[7 - s]));
      apb(12'h0a4 + 12'(4 * (7 - s)), 1'b0, 32'h0, 4'h0, rd, er);
      check(80'(rd), 80'(offs_m[7 - s]));
    end
    // Offset words written over the bus
    lfsr = lfsr_next(lfsr);
    apb(12'h0a8, 1'b1, {16'h0000, lfsr[31:16]}, 4'h3, rd, er);
    offs_m[1] = lfsr[31:16];
    apb(12'h0a8, 1'b0, 32'h0, 4'h0, rd, er);
    check(80'({er, rd}), 80'({1'b0, 16'h0000, offs_m[1]}));
    // Calibration and bus write meet on one offset: calibration wins
    @(posedge core_clk);
    active_setup <= 3'h4;
    cal_valid <= 1'b1;
    cal_offset <= lfsr[15:0];
    offs_m[4] = lfsr[15:0];
    apb(12'h0b4, 1'b1, {16'h0000, ~lfsr[15:0]}, 4'hf, rd, er);
    cal_valid <= 1'b0;
    apb(12'h0b4, 1'b0, 32'h0, 4'h0, rd, er);
    check(80'(rd), 80'(offs_m[4]));
    for (int s = 0; s < 8; s++) show(s);
    // Frozen block ignores its inputs and stalls the bus
    @(posedge core_clk);
    clk_en <= 1'b0;
    active_setup <= 3'h6;
    cal_valid <= 1'b1;
    cal_offset <= ~offs_m[6];
    fork
      apb(12'h07c, 1'b0, 32'h0, 4'h0, rd, er);
      begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check(80'(active_settings), 80'(exp_act(cfg_m[7])));
        check(80'(active_offset), 80'(offs_m[7]));
        check(80'(apb_rsp.pready), 80'(1'b0));
        @(posedge core_clk);
        cal_valid <= 1'b0;
        clk_en <= 1'b1;
      end
    join
    check(80'(rd), 80'(cfg_m[6]));
    show(6);
    // Second reset in mid-run clears everything again
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    reset_check();
    show(5);
    results();
  end
endmodule

// file: verilog/acb_defines.svh
/*
  Constants of the setup configuration bank: register indices, field
  positions, reset values and decoded current magnitudes.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef ACB_DEFINES_SVH
`define ACB_DEFINES_SVH

`define ACB_NUM_SETUPS     8
`define ACB_APB_ADDR_W     12

// Register indices; byte address is four times the index
`define ACB_CFG_FIRST_IDX  8'h19
`define ACB_CFG_LAST_IDX   8'h20
`define ACB_OFFS_FIRST_IDX 8'h29
`define ACB_OFFS_LAST_IDX  8'h30

`define ACB_CFG_RST        16'h0000
`define ACB_OFFS_RST       16'h8000

// Field positions inside a setup word
`define ACB_EXC_B_HI       15
`define ACB_EXC_B_LO       13
`define ACB_EXC_A_HI       12
`define ACB_EXC_A_LO       10
`define ACB_BURN_HI        9
`define ACB_BURN_LO        8
`define ACB_REF_POS_BIT    7
`define ACB_REF_NEG_BIT    6
`define ACB_REF_SEL_HI     5
`define ACB_REF_SEL_LO     4
`define ACB_GAIN_HI        3
`define ACB_GAIN_LO        1
`define ACB_BYPASS_BIT     0

// Excitation magnitudes in nA
`define ACB_EXC_NA_OFF     18'h00000
`define ACB_EXC_NA_10UA    18'h02710
`define ACB_EXC_NA_20UA    18'h04e20
`define ACB_EXC_NA_50UA    18'h0c350
`define ACB_EXC_NA_100UA   18'h186a0
`define ACB_EXC_NA_150UA   18'h249f0
`define ACB_EXC_NA_200UA   18'h30d40
`define ACB_EXC_NA_100NA   18'h00064

// Open-wire current in nA
`define ACB_BURN_NA_OFF    12'h000
`define ACB_BURN_NA_0U5    12'h1f4
`define ACB_BURN_NA_2U     12'h7d0
`define ACB_BURN_NA_4U     12'hfa0

`define ACB_GAIN_UNITY     8'h01

`endif

// file: verilog/acb_pkg.sv
/*
  Types shared by the setup configuration bank: bus carriers, reference
  choice, decoded setup and bus phase.
  Assumes acb_defines.svh is on the include path.
*/
`include "acb_defines.svh"

package acb_pkg;

  typedef struct packed {
    logic [`ACB_APB_ADDR_W-1:0] paddr;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [31:0]                pwdata;
    logic [3:0]                 pstrb;
  } acb_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } acb_apb_rsp_t;

  typedef enum logic [1:0] {
    ext_ref_pair_one    = 2'h0,
    ext_ref_pair_two    = 2'h1,
    internal_ref_output = 2'h2,
    analog_supply_ref   = 2'h3
  } acb_ref_sel_t;

  typedef struct packed {
    logic [2:0]   excite_source_b_level;
    logic [17:0]  excite_b_na;
    logic [2:0]   excite_source_a_level;
    logic [17:0]  excite_a_na;
    logic [1:0]   burnout_level;
    logic [11:0]  burnout_na;
    logic         ref_pos_buffer_on;
    logic         ref_neg_buffer_on;
    acb_ref_sel_t ref_sel;
    logic         amp_bypass;
    logic [2:0]   amp_gain_code;
    logic [7:0]   amp_gain;
  } acb_setup_act_t;

  typedef enum logic [0:0] {
    acb_ph_idle,
    acb_ph_ready
  } acb_phase_t;

endpackage

// file: verilog/acb_setup_bank.sv
/*
  Bank of setup configuration words with per-setup offset storage,
  reached over APB, driving the controls of the setup that the active
  channel selects.
  Assumes an APB master on core_clk and a channel sequencer that supplies
  the active setup index and offset calibration results.
*/
`timescale 1ns/10ps
`include "acb_defines.svh"

module acb_setup_bank
  import acb_pkg::*;
#(
  parameter int NUM_SETUPS = `ACB_NUM_SETUPS
)(
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  input  acb_apb_req_t                       apb_req,
  output acb_apb_rsp_t                       apb_rsp,
  input  wire logic [$clog2(NUM_SETUPS)-1:0] active_setup,
  input  wire logic                          cal_valid,
  input  wire logic [15:0]                   cal_offset,
  output acb_setup_act_t                     active_settings,
  output logic [15:0]                        active_offset
);

  localparam int SEL_W  = $clog2(NUM_SETUPS);
  localparam int WORD_W = `ACB_APB_ADDR_W - 2;

  typedef struct packed {
    acb_phase_t                       phase;
    logic [31:0]                      rd_data;
    logic                             slverr;
    logic [NUM_SETUPS-1:0][15:0]      cfg;
    logic [NUM_SETUPS-1:0][15:0]      offs;
    acb_setup_act_t                   act;
    logic [15:0]                      offs_act;
  } acb_state_t;

  function automatic acb_state_t rst_state();
    acb_state_t s;
    s = '0;
    s.phase = acb_ph_idle;
    for (int i = 0; i < NUM_SETUPS; i++) begin
      s.cfg[i]  = `ACB_CFG_RST;
      s.offs[i] = `ACB_OFFS_RST;
    end
    s.act.amp_gain = `ACB_GAIN_UNITY;
    s.offs_act     = `ACB_OFFS_RST;
    return s;
  endfunction

  // Word aligned and inside [first, last]
  function automatic logic in_range(input logic [`ACB_APB_ADDR_W-1:0] a,
                                    input logic [7:0]                  first,
                                    input logic [7:0]                  last);
    logic [WORD_W-1:0] w;
    w = a[`ACB_APB_ADDR_W-1:2];
    in_range = (a[1:0] == 2'h0) && (w >= WORD_W'(first)) && (w <= WORD_W'(last));
  endfunction

  function automatic logic [SEL_W-1:0] slot_of(input logic [`ACB_APB_ADDR_W-1:0] a,
                                               input logic [7:0]                  first);
    logic [WORD_W-1:0] d;
    d = a[`ACB_APB_ADDR_W-1:2] - WORD_W'(first);
    slot_of = d[SEL_W-1:0];
  endfunction

  // Only the two low byte lanes carry register bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb);
    merge = old;
    if (strb[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  acb_state_t        st;
  acb_state_t        next_st;
  acb_setup_act_t    dec_act;
  logic [15:0]       sel_word;
  logic              hit_cfg;
  logic              hit_offs;
  logic [SEL_W-1:0]  slot_cfg;
  logic [SEL_W-1:0]  slot_offs;
  logic              bus_setup;
  logic              bus_ready;
  logic              bus_done;

  assign sel_word  = st.cfg[active_setup];
  assign hit_cfg   = in_range(apb_req.paddr, `ACB_CFG_FIRST_IDX, `ACB_CFG_LAST_IDX);
  assign hit_offs  = in_range(apb_req.paddr, `ACB_OFFS_FIRST_IDX, `ACB_OFFS_LAST_IDX);
  assign slot_cfg  = slot_of(apb_req.paddr, `ACB_CFG_FIRST_IDX);
  assign slot_offs = slot_of(apb_req.paddr, `ACB_OFFS_FIRST_IDX);
  // A setup cycle missed while frozen is still taken in the access phase
  assign bus_setup = apb_req.psel;
  // A frozen block must not let the master finish a transfer
  assign bus_ready = (st.phase == acb_ph_ready) && clk_en;
  assign bus_done  = apb_req.psel && apb_req.penable && bus_ready;

  acb_setup_decode u_decode (
    .cfg_word (sel_word),
    .act      (dec_act)
  );

  always_comb begin
    next_st = st;
    case (st.phase)
      acb_ph_idle: begin
        if (bus_setup) begin
          next_st.phase  = acb_ph_ready;
          next_st.slverr = !(hit_cfg || hit_offs);
          if (hit_cfg) begin
            next_st.rd_data = {16'h0000, st.cfg[slot_cfg]};
          end else if (hit_offs) begin
            next_st.rd_data = {16'h0000, st.offs[slot_offs]};
          end else begin
            next_st.rd_data = 32'h0000_0000;
          end
        end
      end
      acb_ph_ready: begin
        if (bus_done) begin
          next_st.phase = acb_ph_idle;
          if (apb_req.pwrite && hit_cfg) begin
            next_st.cfg[slot_cfg] = merge(st.cfg[slot_cfg], apb_req.pwdata,
                                          apb_req.pstrb);
          end
          if (apb_req.pwrite && hit_offs) begin
            next_st.offs[slot_offs] = merge(st.offs[slot_offs], apb_req.pwdata,
                                            apb_req.pstrb);
          end
        end else if (!apb_req.psel) begin
          next_st.phase = acb_ph_idle;
        end
      end
      default: begin
        next_st.phase = acb_ph_idle;
      end
    endcase
    // Calibration lands after the bus write so hardware wins a tie
    if (cal_valid) begin
      next_st.offs[active_setup] = cal_offset;
    end
    next_st.act      = dec_act;
    next_st.offs_act = st.offs[active_setup];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= rst_state();
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign apb_rsp.prdata  = st.rd_data;
  assign apb_rsp.pready  = apb_req.psel && apb_req.penable && bus_ready;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && bus_ready && st.slverr;
  assign active_settings = st.act;
  assign active_offset   = st.offs_act;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_cfg_reset;
    $fell(sys_rst) |-> (st.cfg == {NUM_SETUPS{`ACB_CFG_RST}}) && (st.phase == acb_ph_idle);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("setup words not cleared");

  property p_follow_setup;
    clk_en |=> {active_settings.excite_source_b_level, active_settings.excite_source_a_level,
                active_settings.burnout_level} == $past(sel_word[`ACB_EXC_B_HI:`ACB_BURN_LO]);
  endproperty
  a_follow_setup: assert property (p_follow_setup) else $error("wrong setup drives");

  property p_exc_b;
    clk_en && (sel_word[`ACB_EXC_B_HI:`ACB_EXC_B_LO] == 3'h7)
      |=> active_settings.excite_b_na == `ACB_EXC_NA_100NA;
  endproperty
  a_exc_b: assert property (p_exc_b) else $error("second excitation code 7 wrong");

  property p_exc_a;
    clk_en && (sel_word[`ACB_EXC_A_HI:`ACB_EXC_A_LO] == 3'h6)
      |=> active_settings.excite_a_na == `ACB_EXC_NA_200UA;
  endproperty
  a_exc_a: assert property (p_exc_a) else $error("first excitation code 6 wrong");

  property p_burnout;
    clk_en && (sel_word[`ACB_BURN_HI:`ACB_BURN_LO] == 2'h3)
      |=> active_settings.burnout_na == `ACB_BURN_NA_4U;
  endproperty
  a_burnout: assert property (p_burnout) else $error("open-wire current wrong");

  property p_ref_pos;
    clk_en |=> active_settings.ref_pos_buffer_on == $past(sel_word[`ACB_REF_POS_BIT]);
  endproperty
  a_ref_pos: assert property (p_ref_pos) else $error("positive buffer mismatch");

  property p_ref_neg;
    clk_en |=> active_settings.ref_neg_buffer_on == $past(sel_word[`ACB_REF_NEG_BIT]);
  endproperty
  a_ref_neg: assert property (p_ref_neg) else $error("negative buffer mismatch");

  property p_ref_sel;
    clk_en && (sel_word[`ACB_REF_SEL_HI:`ACB_REF_SEL_LO] == 2'h2)
      |=> active_settings.ref_sel == internal_ref_output;
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference source wrong");

  property p_gain;
    clk_en && !sel_word[`ACB_BYPASS_BIT]
      |=> active_settings.amp_gain == (`ACB_GAIN_UNITY << $past(sel_word[`ACB_GAIN_HI:`ACB_GAIN_LO]));
  endproperty
  a_gain: assert property (p_gain) else $error("gain not two to the code");

  property p_bypass;
    clk_en && sel_word[`ACB_BYPASS_BIT]
      |=> active_settings.amp_bypass && (active_settings.amp_gain == `ACB_GAIN_UNITY);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not force unity");

  property p_cal_store;
    clk_en && cal_valid |=> st.offs[$past(active_setup)] == $past(cal_offset);
  endproperty
  a_cal_store: assert property (p_cal_store) else $error("offset not stored per setup");

  property p_read_back;
    apb_rsp.pready && !apb_req.pwrite && hit_cfg
      |-> apb_rsp.prdata == {16'h0000, st.cfg[slot_cfg]} && !apb_rsp.pslverr;
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data differs");

  property p_write_store;
    bus_done && apb_req.pwrite && hit_cfg && (apb_req.pstrb[1:0] == 2'h3)
      |=> st.cfg[$past(slot_cfg)] == $past(apb_req.pwdata[15:0]);
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored");

  property p_freeze;
    !clk_en |=> $stable(st);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_stall;
    !clk_en |-> !apb_rsp.pready;
  endproperty
  a_stall: assert property (p_stall) else $error("bus finished while frozen");

  property p_setup_taken;
    clk_en && apb_req.psel && (st.phase == acb_ph_idle)
      |=> st.phase == acb_ph_ready;
  endproperty
  a_setup_taken: assert property (p_setup_taken) else $error("bus request not taken");

  property p_refuse;
    apb_rsp.pready && !hit_cfg && !hit_offs
      |-> apb_rsp.pslverr && (apb_rsp.prdata == 32'h0000_0000);
  endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped place not refused");

  property p_upper_zero;
    apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

  property p_cfg_only_bus;
    clk_en && !(bus_done && apb_req.pwrite && hit_cfg)
      |=> $stable(st.cfg);
  endproperty
  a_cfg_only_bus: assert property (p_cfg_only_bus) else $error("setup word moved");

  property p_offs_follow;
    clk_en |=> active_offset == $past(st.offs[active_setup]);
  endproperty
  a_offs_follow: assert property (p_offs_follow) else $error("offset not following");

  property p_bypass_code;
    clk_en && sel_word[`ACB_BYPASS_BIT]
      |=> active_settings.amp_gain_code == 3'h0;
  endproperty
  a_bypass_code: assert property (p_bypass_code) else $error("gain code not masked");

  property p_exc_b_off;
    clk_en && (sel_word[`ACB_EXC_B_HI:`ACB_EXC_B_LO] == 3'h0)
      |=> active_settings.excite_b_na == `ACB_EXC_NA_OFF;
  endproperty
  a_exc_b_off: assert property (p_exc_b_off) else $error("excitation not off");

endmodule

// file: verilog/acb_setup_decode.sv
/*
  Turns one raw setup word into the analog front-end controls.
  Purely combinational; the bank registers its result.
*/
`timescale 1ns/10ps
`include "acb_defines.svh"

module acb_setup_decode
  import acb_pkg::*;
(
  input  wire logic [15:0]    cfg_word,
  output acb_setup_act_t      act
);

  function automatic logic [17:0] excite_na(input logic [2:0] code);
    case (code)
      3'h0:    excite_na = `ACB_EXC_NA_OFF;
      3'h1:    excite_na = `ACB_EXC_NA_10UA;
      3'h2:    excite_na = `ACB_EXC_NA_20UA;
      3'h3:    excite_na = `ACB_EXC_NA_50UA;
      3'h4:    excite_na = `ACB_EXC_NA_100UA;
      3'h5:    excite_na = `ACB_EXC_NA_150UA;
      3'h6:    excite_na = `ACB_EXC_NA_200UA;
      default: excite_na = `ACB_EXC_NA_100NA;
    endcase
  endfunction

  always_comb begin
    act.excite_source_b_level = cfg_word[`ACB_EXC_B_HI:`ACB_EXC_B_LO];
    act.excite_b_na           = excite_na(act.excite_source_b_level);
    act.excite_source_a_level = cfg_word[`ACB_EXC_A_HI:`ACB_EXC_A_LO];
    act.excite_a_na           = excite_na(act.excite_source_a_level);
    act.burnout_level         = cfg_word[`ACB_BURN_HI:`ACB_BURN_LO];
    case (act.burnout_level)
      2'h0:    act.burnout_na = `ACB_BURN_NA_OFF;
      2'h1:    act.burnout_na = `ACB_BURN_NA_0U5;
      2'h2:    act.burnout_na = `ACB_BURN_NA_2U;
      default: act.burnout_na = `ACB_BURN_NA_4U;
    endcase
    act.ref_pos_buffer_on = cfg_word[`ACB_REF_POS_BIT];
    act.ref_neg_buffer_on = cfg_word[`ACB_REF_NEG_BIT];
    act.ref_sel = acb_ref_sel_t'(cfg_word[`ACB_REF_SEL_HI:`ACB_REF_SEL_LO]);
    act.amp_bypass = cfg_word[`ACB_BYPASS_BIT];
    if (act.amp_bypass) begin
      // Bypass masks the gain field entirely
      act.amp_gain_code = 3'h0;
      act.amp_gain      = `ACB_GAIN_UNITY;
    end else begin
      act.amp_gain_code = cfg_word[`ACB_GAIN_HI:`ACB_GAIN_LO];
      act.amp_gain      = `ACB_GAIN_UNITY << act.amp_gain_code;
    end
  end

endmodule
